// File: hdl/odg_pkg.sv
// Contract
// RQ1 - With the gain double select bit clear (its reset value) the downconverter output has unity gain.
// RQ2 - With the gain double select bit set the downconverter output is doubled (6.02 dB).
// RQ3 - Software enables the doubling only when the negative image is filtered out, else samples clip.
// RQ4 - Each absolute sample level at or above the in-phase threshold sets control bit 0 on I samples.
// RQ5 - A threshold T means a peak of 20*log10(T/256) dBFS, so T meets the top eight magnitude bits.
// RQ6 - Each absolute sample level at or above the quadrature threshold sets control bit 1 on Q samples.
// RQ7 - While the range pin enable is low all four range pins are low, otherwise they show detection.
// RQ8 - The range pin enable gates only the pins; control bits in the sample stream are always made.
// RQ9 - A range pin pulse lasts at least 8 * 2^exponent clock cycles, the exponent being 3 bits.
// RQ10 - A new crossing during a pulse restarts the stretch count.
// RQ11 - Preset source mode 0 uses the register selects, 1 separate pin pairs, 2 the first pair, 3 reserved.
package odg_pkg;

  localparam int ODG_ADDR_W = 12;
  localparam int ODG_DATA_W = 8;
  localparam logic [11:0] ODG_OFS_GAIN = 12'h210;
  localparam logic [11:0] ODG_OFS_THR_I = 12'h211;
  localparam logic [11:0] ODG_OFS_THR_Q = 12'h212;
  localparam logic [11:0] ODG_OFS_PIN_CFG = 12'h213;
  localparam logic [11:0] ODG_OFS_MODE = 12'h214;

  localparam logic [7:0] ODG_RST_GAIN = 8'h00;
  localparam logic [7:0] ODG_RST_THR_I = 8'hf2;
  localparam logic [7:0] ODG_RST_THR_Q = 8'hab;
  localparam logic [7:0] ODG_RST_PIN_CFG = 8'h07;
  localparam logic [7:0] ODG_RST_MODE = 8'h00;

  localparam int ODG_GAIN_DOUBLE_SELECT_BIT = 0;
  localparam int ODG_PIN_EN_BIT = 3;
  localparam int ODG_STRETCH_LSB = 0;
  localparam int ODG_STRETCH_W = 3;
  localparam int ODG_MODE_LSB = 0;
  localparam int ODG_MODE_W = 2;

  localparam int ODG_ADC_W = 12;
  localparam int ODG_DDC_W = 16;
  localparam int ODG_LEVEL_W = 8;
  localparam int ODG_STRETCH_BASE = 8;
  localparam int ODG_CNT_W = 11;
  localparam int ODG_FIFO_DEPTH = 16;
  localparam int ODG_SYNC_W = 2;

  typedef enum logic [1:0] {
    ODG_MODE_REG = 2'b00,
    ODG_MODE_PIN_SPLIT = 2'b01,
    ODG_MODE_PIN_SHARED = 2'b10,
    ODG_MODE_RSVD = 2'b11
  } odg_mode_e;

  typedef struct packed {
    logic signed [ODG_DDC_W-1:0] i;
    logic signed [ODG_DDC_W-1:0] q;
    logic ctl0;
    logic ctl1;
  } odg_sample_s;

endpackage

// File: hdl/odg_fifo.sv
`timescale 1ns/1ps
module odg_fifo #(
  parameter int W = 34,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready_ff,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready_ff;
  assign out_valid = (count_ff != '0);
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];

  always_comb begin
    case ({push, pop})
      2'b10: nxt_count = count_ff + (AW+1)'(1);
      2'b01: nxt_count = count_ff - (AW+1)'(1);
      default: nxt_count = count_ff;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b1;
    end else if (ce) begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

  // Data storage needs no reset; only control state does
  always_ff @(posedge ref_clk) begin
    if (ce && push) mem[wr_ptr_ff] <= in_data;
  end

endmodule

// File: hdl/odg_top.sv
`timescale 1ns/1ps
module odg_top import odg_pkg::*; #(
  parameter int FIFO_DEPTH = ODG_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ODG_ADDR_W-1:0] reg_addr,
  input wire logic [ODG_DATA_W-1:0] reg_wdata,
  output logic [ODG_DATA_W-1:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  input wire logic adc_a_valid,
  input wire logic signed [ODG_ADC_W-1:0] adc_a_sample,
  input wire logic adc_b_valid,
  input wire logic signed [ODG_ADC_W-1:0] adc_b_sample,
  input wire logic ddc_in_valid,
  input wire logic signed [ODG_DDC_W-1:0] ddc_in_i,
  input wire logic signed [ODG_DDC_W-1:0] ddc_in_q,
  output logic ddc_in_ready,
  output logic ddc_out_valid_ff,
  output odg_sample_s ddc_out_ff,
  input wire logic ddc_out_ready,
  output logic chan_a_range_pin_0,
  output logic chan_a_range_pin_1,
  output logic chan_b_range_pin_0,
  output logic chan_b_range_pin_1,
  input wire logic [1:0] preset_pins_first,
  input wire logic [1:0] preset_pins_second,
  input wire logic [3:0] preset_register_select,
  output logic [1:0] active_preset_a_ff,
  output logic [1:0] active_preset_b_ff
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [ODG_LEVEL_W-1:0] abs_level(input logic signed [ODG_ADC_W-1:0] s);
    logic [ODG_ADC_W-1:0] mag;
    mag = s[ODG_ADC_W-1] ? ODG_ADC_W'(-s) : ODG_ADC_W'(s);
    // Full negative scale has no positive twin; pin it to the top level
    abs_level = mag[ODG_ADC_W-1] ? '1 : mag[ODG_ADC_W-2 -: ODG_LEVEL_W];
  endfunction

  function automatic logic signed [ODG_DDC_W-1:0] gain_apply(
    input logic signed [ODG_DDC_W-1:0] s,
    input logic dbl
  );
    if (!dbl) begin
      gain_apply = s;
    end else if (s[ODG_DDC_W-1] != s[ODG_DDC_W-2]) begin
      // Saturate rather than wrap when the doubled value clips
      gain_apply = s[ODG_DDC_W-1] ? {1'b1, {(ODG_DDC_W-1){1'b0}}} : {1'b0, {(ODG_DDC_W-1){1'b1}}};
    end else begin
      gain_apply = {s[ODG_DDC_W-2:0], 1'b0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] gain_cfg_ff;
  logic [7:0] thr_i_ff;
  logic [7:0] thr_q_ff;
  logic [7:0] pin_cfg_ff;
  logic [7:0] mode_cfg_ff;

  logic gain_double_select;
  logic [ODG_LEVEL_W-1:0] inphase_level_threshold;
  logic [ODG_LEVEL_W-1:0] quadrature_level_threshold;
  logic range_pin_enable;
  logic [ODG_STRETCH_W-1:0] pulse_stretch_exponent;
  odg_mode_e preset_source_mode;

  assign gain_double_select = gain_cfg_ff[ODG_GAIN_DOUBLE_SELECT_BIT];
  assign inphase_level_threshold = thr_i_ff;
  assign quadrature_level_threshold = thr_q_ff;
  assign range_pin_enable = pin_cfg_ff[ODG_PIN_EN_BIT];
  assign pulse_stretch_exponent = pin_cfg_ff[ODG_STRETCH_LSB +: ODG_STRETCH_W];
  assign preset_source_mode = odg_mode_e'(mode_cfg_ff[ODG_MODE_LSB +: ODG_MODE_W]);

  // Reserved bits are plain read/write storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_cfg_ff <= ODG_RST_GAIN;
      thr_i_ff <= ODG_RST_THR_I;
      thr_q_ff <= ODG_RST_THR_Q;
      pin_cfg_ff <= ODG_RST_PIN_CFG;
      mode_cfg_ff <= ODG_RST_MODE;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        ODG_OFS_GAIN: gain_cfg_ff <= reg_wdata;
        ODG_OFS_THR_I: thr_i_ff <= reg_wdata;
        ODG_OFS_THR_Q: thr_q_ff <= reg_wdata;
        ODG_OFS_PIN_CFG: pin_cfg_ff <= reg_wdata;
        ODG_OFS_MODE: mode_cfg_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= '0;
      reg_rvalid_ff <= 1'b0;
    end else if (ce) begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ODG_OFS_GAIN: reg_rdata_ff <= gain_cfg_ff;
          ODG_OFS_THR_I: reg_rdata_ff <= thr_i_ff;
          ODG_OFS_THR_Q: reg_rdata_ff <= thr_q_ff;
          ODG_OFS_PIN_CFG: reg_rdata_ff <= pin_cfg_ff;
          ODG_OFS_MODE: reg_rdata_ff <= mode_cfg_ff;
          default: reg_rdata_ff <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [ODG_LEVEL_W-1:0] level_a;
  logic [ODG_LEVEL_W-1:0] level_b;
  logic [3:0] hit;

  assign level_a = abs_level(adc_a_sample); // RQ5
  assign level_b = abs_level(adc_b_sample); // RQ5
  assign hit[0] = adc_a_valid && (level_a >= inphase_level_threshold); // RQ4
  assign hit[1] = adc_a_valid && (level_a >= quadrature_level_threshold); // RQ6
  assign hit[2] = adc_b_valid && (level_b >= inphase_level_threshold);
  assign hit[3] = adc_b_valid && (level_b >= quadrature_level_threshold);

  ////////////////////////////////////////////////////////////////////////////
  logic [ODG_CNT_W-1:0] stretch_len;
  logic [ODG_CNT_W-1:0] stretch_cnt_ff [4];
  logic [3:0] pin_ff;

  assign stretch_len = ODG_CNT_W'(ODG_STRETCH_BASE) << pulse_stretch_exponent; // RQ9

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ff <= '0;
      for (int k = 0; k < 4; k++) stretch_cnt_ff[k] <= '0;
    end else if (ce) begin
      for (int k = 0; k < 4; k++) begin
        if (hit[k]) begin
          stretch_cnt_ff[k] <= stretch_len - ODG_CNT_W'(1); // RQ10
        end else if (stretch_cnt_ff[k] != '0) begin
          stretch_cnt_ff[k] <= stretch_cnt_ff[k] - ODG_CNT_W'(1);
        end
        // Counting runs while disabled so enabling never shows a stale edge
        pin_ff[k] <= range_pin_enable && (hit[k] || stretch_cnt_ff[k] != '0); // RQ7 RQ9
      end
    end
  end

  assign chan_a_range_pin_0 = pin_ff[0];
  assign chan_a_range_pin_1 = pin_ff[1];
  assign chan_b_range_pin_0 = pin_ff[2];
  assign chan_b_range_pin_1 = pin_ff[3];

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] ctl_sticky_ff;
  logic take;
  odg_sample_s push_word;
  logic fifo_valid;
  odg_sample_s fifo_data;
  logic fifo_pop;

  assign take = ce && ddc_in_valid && ddc_in_ready;
  assign push_word.i = gain_apply(ddc_in_i, gain_double_select); // RQ1 RQ2
  assign push_word.q = gain_apply(ddc_in_q, gain_double_select); // RQ1 RQ2
  // Stream bits ignore the pin enable; a crossing in the take cycle is kept
  assign push_word.ctl0 = ctl_sticky_ff[0] || hit[0]; // RQ4 RQ8
  assign push_word.ctl1 = ctl_sticky_ff[1] || hit[1]; // RQ6 RQ8

  // Decimated stream: crossings between two samples collect here, set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_sticky_ff <= '0;
    end else if (ce) begin
      ctl_sticky_ff <= (take ? 2'b00 : ctl_sticky_ff) | hit[1:0];
    end
  end

  assign fifo_pop = ce && (!ddc_out_valid_ff || ddc_out_ready);

  odg_fifo #(.W($bits(odg_sample_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(ddc_in_valid),
    .in_data(push_word),
    .in_ready_ff(ddc_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ddc_out_valid_ff <= 1'b0;
      ddc_out_ff <= '0;
    end else if (fifo_pop) begin
      ddc_out_valid_ff <= fifo_valid;
      if (fifo_valid) ddc_out_ff <= fifo_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [ODG_SYNC_W-1:0] first_meta_ff;
  logic [ODG_SYNC_W-1:0] first_sync_ff;
  logic [ODG_SYNC_W-1:0] second_meta_ff;
  logic [ODG_SYNC_W-1:0] second_sync_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_meta_ff <= '0;
      first_sync_ff <= '0;
      second_meta_ff <= '0;
      second_sync_ff <= '0;
    end else if (ce) begin
      first_meta_ff <= preset_pins_first;
      first_sync_ff <= first_meta_ff;
      second_meta_ff <= preset_pins_second;
      second_sync_ff <= second_meta_ff;
    end
  end

  // Reserved mode keeps the last preset instead of guessing one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_preset_a_ff <= '0;
      active_preset_b_ff <= '0;
    end else if (ce) begin
      case (preset_source_mode) // RQ11
        ODG_MODE_REG: begin
          active_preset_a_ff <= preset_register_select[1:0];
          active_preset_b_ff <= preset_register_select[3:2];
        end
        ODG_MODE_PIN_SPLIT: begin
          active_preset_a_ff <= first_sync_ff;
          active_preset_b_ff <= second_sync_ff;
        end
        ODG_MODE_PIN_SHARED: begin
          active_preset_a_ff <= first_sync_ff;
          active_preset_b_ff <= first_sync_ff;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_unity_gain: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ1
    (take && !gain_double_select) |-> (push_word.i == ddc_in_i && push_word.q == ddc_in_q))
    else $error("unity gain not applied");

  chk_double_gain: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ2
    (take && gain_double_select && ddc_in_i[ODG_DDC_W-1] == ddc_in_i[ODG_DDC_W-2])
    |-> (push_word.i == ddc_in_i <<< 1))
    else $error("doubled gain wrong");

  chk_inphase_ctl: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ4
    (ce && adc_a_valid && level_a >= inphase_level_threshold && !take) |=> ctl_sticky_ff[0])
    else $error("in-phase crossing lost");

  chk_level_scale: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ5
    (!adc_a_sample[ODG_ADC_W-1]) |-> (level_a == adc_a_sample[ODG_ADC_W-2 -: ODG_LEVEL_W]))
    else $error("level scaling wrong");

  chk_quad_ctl: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ6
    (ce && adc_a_valid && level_a >= quadrature_level_threshold && !take) |=> ctl_sticky_ff[1])
    else $error("quadrature crossing lost");

  chk_pins_gated: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ7
    (ce && !range_pin_enable) |=> (pin_ff == 4'h0))
    else $error("range pin high while disabled");

  chk_ctl_ungated: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
    (take && hit[0] && !range_pin_enable) |-> push_word.ctl0)
    else $error("stream bit gated by pin enable");

  chk_stretch_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ9
    (ce && hit[0] && range_pin_enable)
    |=> (pin_ff[0] && stretch_cnt_ff[0] == $past(stretch_len) - ODG_CNT_W'(1)))
    else $error("stretch count not loaded");

  chk_stretch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
    (ce && range_pin_enable && stretch_cnt_ff[0] != '0) |=> pin_ff[0])
    else $error("pin dropped during stretch");

  chk_preset_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ11
    (ce && preset_source_mode == ODG_MODE_PIN_SHARED)
    |=> (active_preset_a_ff == $past(first_sync_ff) && active_preset_b_ff == $past(first_sync_ff)))
    else $error("shared preset pins not used");

endmodule

// File: sim/odg_pin_monitor.sv
`timescale 1ns/1ps
// Board-side watcher of the four range pins; counts pulses below the minimum length
module odg_pin_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] pins,
  input wire logic [2:0] stretch_n,
  output logic [15:0] short_count
);
  int run [4];
  int s;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      short_count <= '0;
      foreach (run[k]) run[k] <= 0;
    end else begin
      s = 0;
      foreach (run[k]) begin
        if (pins[k]) begin
          run[k] <= run[k] + 1;
        end else begin
          if (run[k] != 0 && run[k] < (8 << stretch_n)) s++;
          run[k] <= 0;
        end
      end
      short_count <= short_count + 16'(s);
    end
  end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import odg_pkg::*;
  logic ref_clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata_ff;
  logic reg_rvalid_ff, adc_a_valid = 0, adc_b_valid = 0, ddc_in_valid = 0, ddc_out_ready = 0;
  logic signed [11:0] adc_a_sample = 0, adc_b_sample = 0;
  logic signed [15:0] ddc_in_i = 0, ddc_in_q = 0;
  logic ddc_in_ready, ddc_out_valid_ff;
  odg_sample_s ddc_out_ff, e;
  logic pa0, pa1, pb0, pb1;
  logic [1:0] preset_pins_first = 0, preset_pins_second = 0, active_preset_a_ff, active_preset_b_ff;
  logic [1:0] ea = 0, eb = 0;
  logic [3:0] preset_register_select = 0, h, pexp = 0;
  logic [7:0] mreg [5];
  logic [31:0] seed = 32'h0001_0c9a, r, v;
  logic [15:0] short_count;
  logic tr = 0, stall = 0, st0, st1;
  int n_fail = 0, check_count = 0, cyc = 0;
  int cnt [4];
  odg_sample_s q [$];

  odg_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .adc_a_valid(adc_a_valid), .adc_a_sample(adc_a_sample),
    .adc_b_valid(adc_b_valid), .adc_b_sample(adc_b_sample), .ddc_in_valid(ddc_in_valid),
    .ddc_in_i(ddc_in_i), .ddc_in_q(ddc_in_q), .ddc_in_ready(ddc_in_ready),
    .ddc_out_valid_ff(ddc_out_valid_ff), .ddc_out_ff(ddc_out_ff), .ddc_out_ready(ddc_out_ready),
    .chan_a_range_pin_0(pa0), .chan_a_range_pin_1(pa1), .chan_b_range_pin_0(pb0),
    .chan_b_range_pin_1(pb1), .preset_pins_first(preset_pins_first),
    .preset_pins_second(preset_pins_second), .preset_register_select(preset_register_select),
    .active_preset_a_ff(active_preset_a_ff), .active_preset_b_ff(active_preset_b_ff));
  odg_pin_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n), .pins({pb1, pb0, pa1, pa0}),
    .stretch_n(mreg[3][2:0]), .short_count(short_count));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Magnitude clamps so that the most negative code reads as full scale
  function automatic int lvl(logic signed [11:0] x);
    int a = (x < 0) ? -x : x;
    return ((a > 2047) ? 2047 : a) >> 3;
  endfunction
  function automatic logic [15:0] gain(logic signed [15:0] x, logic b);
    int g = b ? 2 * x : x;
    if (g > 32767) g = 32767;
    if (g < -32768) g = -32768;
    return g[15:0];
  endfunction
  function automatic logic [7:0] mx(logic [11:0] a);
    return (a >= 12'h210 && a <= 12'h214) ? mreg[a - 12'h210] : 8'h00;
  endfunction

  task results;
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(negedge ref_clk);
    `CHK(reg_rvalid_ff, 1'b1)
    `CHK(reg_rdata_ff, mx(a))
  endtask
  task run(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    r = xs();
    adc_a_valid <= tr & r[0];
    adc_b_valid <= tr & r[1];
    adc_a_sample <= r[13:2];
    adc_b_sample <= r[25:14];
    r = xs();
    ddc_in_valid <= tr & r[0];
    ddc_in_i <= r[16:1];
    ddc_in_q <= r[31:16];
    ddc_out_ready <= !stall & (r[17] | !tr);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference model; sees the inputs as the design samples them at each edge
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mreg = '{8'h00, 8'hf2, 8'hab, 8'h07, 8'h00};
      foreach (cnt[k]) cnt[k] = 0;
      pexp = 0;
      st0 = 0;
      st1 = 0;
      q.delete();
    end else if (ce) begin
      for (int k = 0; k < 4; k++) begin
        h[k] = (k < 2 ? adc_a_valid : adc_b_valid) &&
          lvl(k < 2 ? adc_a_sample : adc_b_sample) >= mreg[1 + k % 2];
        cnt[k] = h[k] ? (8 << mreg[3][2:0]) : (cnt[k] > 0 ? cnt[k] - 1 : 0);
        pexp[k] = mreg[3][3] && cnt[k] > 0;
      end
      if (ddc_in_valid && ddc_in_ready) begin
        e.i = gain(ddc_in_i, mreg[0][0]);
        e.q = gain(ddc_in_q, mreg[0][0]);
        e.ctl0 = st0 | h[0];
        e.ctl1 = st1 | h[1];
        q.push_back(e);
        st0 = h[0];
        st1 = h[1];
      end else begin
        st0 |= h[0];
        st1 |= h[1];
      end
      // Pop once before the compare; an empty queue is a mismatch, not a silent zero
      if (ddc_out_valid_ff && ddc_out_ready) begin
        e = (q.size() > 0) ? q.pop_front() : 'x;
        `CHK(ddc_out_ff, e)
      end
      if (reg_wr && mx(reg_addr) !== 8'hxx && reg_addr >= 12'h210 && reg_addr <= 12'h214)
        mreg[reg_addr - 12'h210] = reg_wdata;
    end
  end
  always @(negedge ref_clk) if (rst_n) `CHK({pb1, pb0, pa1, pa0}, pexp)

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    run(8);
    rst_n <= 1;
    for (int a = 0; a < 6; a++) rd(12'h210 + 12'(a));
    for (int a = 0; a < 6; a++) begin
      v = xs();
      wr(12'h210 + 12'(a), v[7:0]);
    end
    for (int a = 0; a < 6; a++) rd(12'h210 + 12'(a));
    // Strobe while frozen must leave the register alone
    @(posedge ref_clk);
    ce <= 0;
    reg_wr <= 1;
    reg_addr <= 12'h211;
    reg_wdata <= ~mreg[1];
    @(posedge ref_clk);
    ce <= 1;
    reg_wr <= 0;
    rd(12'h211);
    wr(12'h210, 8'h00);
    wr(12'h211, 8'h80);
    wr(12'h212, 8'h40);
    wr(12'h213, 8'h08);
    // Long default stretch from the random writes must drain first
    run(1100);
    tr <= 1;
    run(600);
    tr <= 0;
    run(60);
    wr(12'h213, 8'h0a);
    wr(12'h211, 8'hff);
    wr(12'h212, 8'h00);
    wr(12'h210, 8'h01);
    tr <= 1;
    run(600);
    tr <= 0;
    run(60);
    wr(12'h213, 8'h02);
    wr(12'h212, 8'h90);
    tr <= 1;
    stall <= 1;
    run(60);
    @(negedge ref_clk);
    `CHK(ddc_in_ready, 1'b0)
    stall <= 0;
    run(200);
    tr <= 0;
    run(100);
    @(negedge ref_clk);
    `CHK(ddc_out_valid_ff, 1'b0)
    `CHK(q.size(), 0)
    for (int m = 0; m < 4; m++) begin
      wr(12'h214, 8'(m));
      @(posedge ref_clk);
      v = xs();
      preset_pins_first <= v[1:0];
      preset_pins_second <= v[3:2];
      preset_register_select <= v[7:4];
      if (m == 0) {eb, ea} = v[7:4];
      if (m == 1) {eb, ea} = v[3:0];
      if (m == 2) {eb, ea} = {v[1:0], v[1:0]};
      run(6);
      @(negedge ref_clk);
      `CHK(active_preset_a_ff, ea)
      `CHK(active_preset_b_ff, eb)
    end
    `CHK(short_count, 16'h0000)
    results;
  end
endmodule
